// ===== src/lpa_regs.sv
// Purpose: Link partner ability register with base and next page views
// Assumes: Negotiation engine on clk delivers received pages and completion
// Notes: All ability fields are read-only; writes only reach interrupt regs
//
// Added by the designer: strobed register access.
`include "lpa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lpa_regs #(
  parameter int CNT_W = `LPA_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire lpa_pkg::lpa_bus_req_s bus_req,
  output logic [15:0] bus_rdata,
  // Negotiation engine
  input wire lpa_pkg::lpa_rx_page_s rx_page,
  input wire logic an_complete,
  input wire logic an_restart,
  input wire logic local_np_able,
  // Decoded partner abilities
  output lpa_pkg::lpa_base_view_s partner_base,
  output logic view_is_next,
  // Interrupt
  output logic irq
);

  // ========================================================================
  // State
  typedef struct packed {
    lpa_pkg::lpa_an_e an_state;
    logic [15:0] rdata;
    logic [CNT_W-1:0] base_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic rf_seen;
  } lpa_main_s;

  lpa_main_s st_q;
  lpa_main_s st_d;

  // ========================================================================
  // Decode helpers
  function automatic logic hit(input lpa_pkg::lpa_bus_req_s req, input logic [4:0] addr);
    hit = req.addr == addr;
  endfunction : hit

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_W'(`LPA_CNT_MAX)) ? v : v + CNT_W'(`LPA_CNT_ONE);
  endfunction : sat_inc

  // Next view decode is shared by the read path, status and events
  function automatic logic next_view_on(input lpa_pkg::lpa_an_e s);
    next_view_on = s == lpa_pkg::AN_DONE_NEXT;
  endfunction : next_view_on

  // Interrupt registers are narrow; upper bits read zero
  function automatic logic [15:0] irq_word(input logic [`LPA_IRQ_N-1:0] v);
    irq_word = `LPA_ZERO16;
    irq_word[`LPA_IRQ_N-1:0] = v;
  endfunction : irq_word

  // Unmapped addresses read zero, so software can probe safely
  function automatic logic [15:0] read_mux(
    input logic [4:0] addr,
    input logic [15:0] ability,
    input logic [15:0] status,
    input logic [`LPA_IRQ_N-1:0] ist,
    input logic [`LPA_IRQ_N-1:0] imask
  );
    case (addr)
      `LPA_ADDR_ABILITY: read_mux = ability;
      `LPA_ADDR_STATUS: read_mux = status;
      `LPA_ADDR_IRQ_STAT: read_mux = irq_word(ist);
      `LPA_ADDR_IRQ_MASK: read_mux = irq_word(imask);
      default: read_mux = `LPA_ZERO16;
    endcase
  endfunction : read_mux

  // ========================================================================
  // Page storage
  logic base_load;
  logic next_load;
  logic [15:0] base_word;
  logic [15:0] next_word;
  logic base_loaded;
  logic next_loaded;

  // Only the engine fills the pages; bus writes never reach them
  assign base_load = rx_page.valid & ~rx_page.is_next;
  assign next_load = rx_page.valid & rx_page.is_next;

  lpa_page_capture #(
    .WIDTH(16),
    .RSVD_MASK(`LPA_BASE_RSVD_MASK)
  ) u_base (
    .clk(clk),
    .rst_b(rst_b),
    .load(base_load),
    .clear(an_restart),
    .din(rx_page.word),
    .dout(base_word),
    .loaded(base_loaded)
  );

  lpa_page_capture #(
    .WIDTH(16),
    .RSVD_MASK(`LPA_NEXT_RSVD_MASK)
  ) u_next (
    .clk(clk),
    .rst_b(rst_b),
    .load(next_load),
    .clear(an_restart),
    .din(rx_page.word),
    .dout(next_word),
    .loaded(next_loaded)
  );

  // ========================================================================
  // Views
  lpa_pkg::lpa_base_view_s base_view;
  lpa_pkg::lpa_next_view_s next_view;
  logic [15:0] ability_word;
  logic np_ok;
  lpa_pkg::lpa_base_view_s base_out;
  lpa_pkg::lpa_next_view_s next_out;

  always_comb begin
    base_view = lpa_pkg::lpa_base_view_s'(base_word);
    base_view.reserved = 1'b0;
    next_view = lpa_pkg::lpa_next_view_s'(next_word);
  end

  // Next pages are shown only when both ends can page; next_cnt counts them regardless
  assign np_ok = local_np_able & base_view.next_page_request;

  // Field by field, so every bit position is fixed by the view type
  always_comb begin
    next_out = '0;
    next_out.next_page_request = next_view.next_page_request;
    next_out.ack = next_view.ack;
    next_out.message_page_flag = next_view.message_page_flag;
    next_out.comply_acknowledge = next_view.comply_acknowledge;
    next_out.toggle = next_view.toggle;
    next_out.code = next_view.code;
    base_out = '0;
    base_out.next_page_request = base_view.next_page_request;
    base_out.ack = base_view.ack;
    base_out.remote_fault_flag = base_view.remote_fault_flag;
    base_out.reserved = 1'b0;
    base_out.asymmetric_pause_cap = base_view.asymmetric_pause_cap;
    base_out.sym_pause_cap = base_view.sym_pause_cap;
    base_out.four_pair_100m_cap = base_view.four_pair_100m_cap;
    base_out.fast_full_duplex_cap = base_view.fast_full_duplex_cap;
    base_out.fast_half_duplex_cap = base_view.fast_half_duplex_cap;
    base_out.slow_full_duplex_cap = base_view.slow_full_duplex_cap;
    base_out.slow_half_duplex_cap = base_view.slow_half_duplex_cap;
    base_out.selector = base_view.selector;
    // One address, two layouts: the state picks which one software sees
    ability_word = `LPA_ZERO16;
    if (next_view_on(st_q.an_state)) begin
      ability_word = next_out;
    end else begin
      ability_word = base_out;
    end
  end

  // ========================================================================
  // Interrupt events
  logic [`LPA_IRQ_N-1:0] evt;
  logic [`LPA_IRQ_N-1:0] irq_status;
  logic [`LPA_IRQ_N-1:0] irq_mask;
  logic view_enter;
  logic base_changed;
  logic irq_clr_wr;
  logic irq_mask_wr;

  assign view_enter = next_view_on(st_d.an_state) & ~next_view_on(st_q.an_state);
  assign base_changed = base_load & base_loaded
                      & ((rx_page.word & ~`LPA_BASE_RSVD_MASK) != base_word);

  always_comb begin
    evt = `LPA_IRQ_RESET;
    evt[`LPA_IRQ_BASE_RX] = base_load;
    evt[`LPA_IRQ_NEXT_RX] = next_load;
    evt[`LPA_IRQ_VIEW_NEXT] = view_enter;
    evt[`LPA_IRQ_RFAULT] = base_load & rx_page.word[`LPA_BIT_RF] & ~st_q.rf_seen;
    evt[`LPA_IRQ_BASE_CHG] = base_changed;
  end

  assign irq_clr_wr = bus_req.wr & hit(bus_req, `LPA_ADDR_IRQ_STAT);
  assign irq_mask_wr = bus_req.wr & hit(bus_req, `LPA_ADDR_IRQ_MASK);

  lpa_irq #(
    .N(`LPA_IRQ_N)
  ) u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .evt(evt),
    .clr_wr(irq_clr_wr),
    .mask_wr(irq_mask_wr),
    .wdata(bus_req.wdata[`LPA_IRQ_N-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ========================================================================
  // Status word: view, state, page counts
  logic [15:0] status_word;

  always_comb begin
    status_word = `LPA_ZERO16;
    status_word[`LPA_ST_VIEW] = next_view_on(st_q.an_state);
    status_word[`LPA_ST_BASE_HELD] = base_loaded;
    status_word[`LPA_ST_NEXT_HELD] = next_loaded;
    status_word[`LPA_ST_NP_OK] = np_ok;
    status_word[`LPA_ST_STATE_LO +: $bits(lpa_pkg::lpa_an_e)] = st_q.an_state;
    // Counts saturate so a flapping link cannot wrap back to zero
    status_word[`LPA_ST_BASE_CNT_LO +: CNT_W] = st_q.base_cnt;
    status_word[`LPA_ST_NEXT_CNT_LO +: CNT_W] = st_q.next_cnt;
  end

  // ========================================================================
  // Negotiation tracking and read port
  always_comb begin
    st_d = st_q;
    // Read data stands for one cycle only
    st_d.rdata = `LPA_ZERO16;
    if (bus_req.rd) begin
      st_d.rdata = read_mux(bus_req.addr, ability_word, status_word, irq_status, irq_mask);
    end

    if (base_load) begin
      st_d.base_cnt = sat_inc(st_q.base_cnt);
      st_d.rf_seen = rx_page.word[`LPA_BIT_RF];
    end
    if (next_load) begin
      st_d.next_cnt = sat_inc(st_q.next_cnt);
    end

    case (st_q.an_state)
      lpa_pkg::AN_IDLE: begin
        if (base_load) begin
          st_d.an_state = lpa_pkg::AN_BASE_RCVD;
        end
      end
      lpa_pkg::AN_BASE_RCVD: begin
        // Switch only once negotiation has succeeded
        if (an_complete) begin
          if (np_ok && next_loaded) begin
            st_d.an_state = lpa_pkg::AN_DONE_NEXT;
          end else begin
            st_d.an_state = lpa_pkg::AN_DONE_BASE;
          end
        end
      end
      lpa_pkg::AN_DONE_BASE: begin
        if (!an_complete) begin
          st_d.an_state = lpa_pkg::AN_BASE_RCVD;
        end
      end
      lpa_pkg::AN_DONE_NEXT: begin
        // Link loss falls back to the base view
        if (!an_complete) begin
          st_d.an_state = lpa_pkg::AN_BASE_RCVD;
        end
      end
      default: begin
        st_d.an_state = lpa_pkg::AN_IDLE;
      end
    endcase

    // Restart discards everything learned about the partner
    if (an_restart) begin
      st_d.an_state = lpa_pkg::AN_IDLE;
      st_d.base_cnt = CNT_W'(`LPA_CNT_ZERO);
      st_d.next_cnt = CNT_W'(`LPA_CNT_ZERO);
      st_d.rf_seen = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs
  assign bus_rdata = st_q.rdata;
  assign partner_base = base_view;
  assign view_is_next = next_view_on(st_q.an_state);

endmodule : lpa_regs

`default_nettype wire

// ===== src/lpa_map.svh
// Purpose: Address map, field positions and reset values of the partner ability block
// Assumes: 5-bit management register address, 16-bit data
// Notes: Definitions only
`ifndef LPA_MAP_SVH
`define LPA_MAP_SVH

// ==========================================================================
// Addresses
`define LPA_ADDR_W 5
`define LPA_DATA_W 16
`define LPA_ADDR_ABILITY 5'h05
`define LPA_ADDR_STATUS 5'h18
`define LPA_ADDR_IRQ_STAT 5'h19
`define LPA_ADDR_IRQ_MASK 5'h1a

// ==========================================================================
// Field positions and reset values
`define LPA_BIT_NP 15
`define LPA_BIT_ACK 14
`define LPA_BIT_RF 13
`define LPA_BASE_RSVD_MASK 16'h1000
`define LPA_NEXT_RSVD_MASK 16'h0000
`define LPA_WORD_RESET 16'h0000
`define LPA_ZERO16 16'h0000

// ==========================================================================
// Status register fields
`define LPA_ST_VIEW 0
`define LPA_ST_BASE_HELD 1
`define LPA_ST_NEXT_HELD 2
`define LPA_ST_NP_OK 3
`define LPA_ST_STATE_LO 4
`define LPA_ST_BASE_CNT_LO 8
`define LPA_ST_NEXT_CNT_LO 12

// ==========================================================================
// Interrupt events
`define LPA_IRQ_N 5
`define LPA_IRQ_BASE_RX 0
`define LPA_IRQ_NEXT_RX 1
`define LPA_IRQ_VIEW_NEXT 2
`define LPA_IRQ_RFAULT 3
`define LPA_IRQ_BASE_CHG 4
`define LPA_IRQ_RESET 5'h00

// ==========================================================================
// Page counters
`define LPA_CNT_W 4
`define LPA_CNT_ZERO 4'h0
`define LPA_CNT_ONE 4'h1
`define LPA_CNT_MAX 4'hf

`endif

// ===== src/lpa_pkg.sv
// Purpose: Types shared by the partner ability block
// Assumes: Field layout follows the 16-bit ability word, bit 15 first
// Notes: Constants live in lpa_map.svh
package lpa_pkg;

  // ========================================================================
  // Register bus request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lpa_bus_req_s;

  // ========================================================================
  // Received link code word from the negotiation engine
  typedef struct packed {
    logic valid;
    logic is_next;
    logic [15:0] word;
  } lpa_rx_page_s;

  // ========================================================================
  // Base page view, bit 15 down to bit 0
  typedef struct packed {
    logic next_page_request;
    logic ack;
    logic remote_fault_flag;
    logic reserved;
    logic asymmetric_pause_cap;
    logic sym_pause_cap;
    logic four_pair_100m_cap;
    logic fast_full_duplex_cap;
    logic fast_half_duplex_cap;
    logic slow_full_duplex_cap;
    logic slow_half_duplex_cap;
    logic [4:0] selector;
  } lpa_base_view_s;

  // Next page view, bit 15 down to bit 0
  typedef struct packed {
    logic next_page_request;
    logic ack;
    logic message_page_flag;
    logic comply_acknowledge;
    logic toggle;
    logic [10:0] code;
  } lpa_next_view_s;

  // ========================================================================
  // Negotiation tracking
  typedef enum logic [1:0] {
    AN_IDLE,
    AN_BASE_RCVD,
    AN_DONE_BASE,
    AN_DONE_NEXT
  } lpa_an_e;

endpackage : lpa_pkg

// ===== src/lpa_page_capture.sv
// Purpose: Holds one received 16-bit page, reserved bits forced low
// Assumes: load and clear are single-cycle strobes on clk
// Notes: clear wins over load, a restart discards the page in flight
`include "lpa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lpa_page_capture #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RSVD_MASK = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic clear,
  input wire logic [WIDTH-1:0] din,
  // Stored page
  output logic [WIDTH-1:0] dout,
  output logic loaded
);

  typedef struct packed {
    logic [WIDTH-1:0] word;
    logic loaded;
  } lpa_cap_s;

  lpa_cap_s st_q;
  lpa_cap_s st_d;

  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.word = '0;
      st_d.loaded = 1'b0;
    end else if (load) begin
      st_d.word = din & ~RSVD_MASK;
      st_d.loaded = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.word;
  assign loaded = st_q.loaded;

endmodule : lpa_page_capture

`default_nettype wire

// ===== src/lpa_irq.sv
// Purpose: Sticky event bits, write-one-to-clear, mask, one level interrupt
// Assumes: Events are single-cycle pulses on clk
// Notes: An event in the clearing cycle survives the clear
`include "lpa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lpa_irq #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Events
  input wire logic [N-1:0] evt,
  // Software access
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } lpa_irq_st_s;

  lpa_irq_st_s st_q;
  lpa_irq_st_s st_d;

  always_comb begin
    st_d = st_q;
    // Set after clear so a same-cycle event is kept
    if (clr_wr) begin
      st_d.status = st_q.status & ~wdata;
    end
    st_d.status = st_d.status | evt;
    if (mask_wr) begin
      st_d.mask = wdata;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;
  assign mask = st_q.mask;
  assign irq = st_q.irq;

endmodule : lpa_irq

`default_nettype wire

// ===== dv/lpa_peer.sv
// Purpose: Negotiation engine model feeding received pages
// Assumes: Driven from the bench through tasks
// Notes: Released page word shows the inverse of the last page
`timescale 1ns/1ps
`default_nettype none

module lpa_peer (
  // Clock
  input wire logic clk,
  // Negotiation side
  output var lpa_pkg::lpa_rx_page_s rx_page,
  output var logic an_complete,
  output var logic an_restart,
  output var logic local_np_able
);
  initial begin
    rx_page = '0;
    an_complete = 1'b0;
    an_restart = 1'b0;
    local_np_able = 1'b0;
  end

  task automatic send(input logic nxt, input logic [15:0] w);
    @(posedge clk);
    rx_page <= '{valid: 1'b1, is_next: nxt, word: w};
    @(posedge clk);
    // Stale data must not pass for a fresh page
    rx_page <= '{valid: 1'b0, is_next: ~nxt, word: ~w};
  endtask : send

  task automatic cfg(input logic done, input logic np);
    @(posedge clk);
    an_complete <= done;
    local_np_able <= np;
  endtask : cfg

  task automatic restart();
    @(posedge clk);
    an_restart <= 1'b1;
    @(posedge clk);
    an_restart <= 1'b0;
  endtask : restart
endmodule : lpa_peer

`default_nettype wire

// ===== dv/lpa_regs_chk.sv
// Purpose: Port assertions for the partner ability block
// Assumes: One clock, rst_b async active low
// Notes: Bound into every lpa_regs
`timescale 1ns/1ps
`default_nettype none

module lpa_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire lpa_pkg::lpa_bus_req_s bus_req,
  input wire logic [15:0] bus_rdata,
  // Negotiation engine
  input wire lpa_pkg::lpa_rx_page_s rx_page,
  input wire logic an_complete,
  input wire logic an_restart,
  input wire logic local_np_able,
  // Outputs
  input wire lpa_pkg::lpa_base_view_s partner_base,
  input wire logic view_is_next,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rdata_idle_a: assert property (
    !bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data not idle");
  rsvd_zero_a: assert property (
    partner_base.reserved == 1'b0)
    else $error("reserved bit set");
  base_load_a: assert property (
    rx_page.valid && !rx_page.is_next && !an_restart
    |=> partner_base == ($past(rx_page.word) & 16'hefff))
    else $error("base page not stored");
  base_hold_a: assert property (
    !(rx_page.valid && !rx_page.is_next) && !an_restart |=> $stable(partner_base))
    else $error("base page changed");
  restart_clr_a: assert property (
    an_restart |=> partner_base == 16'h0000 && !view_is_next)
    else $error("restart did not clear");
  view_drop_a: assert property (
    !an_complete |=> !view_is_next)
    else $error("next view without completion");
  view_rise_a: assert property (
    $rose(view_is_next) |-> $past(an_complete) && $past(local_np_able))
    else $error("next view without cause");
  base_read_a: assert property (
    bus_req.rd && bus_req.addr == 5'h05 && !view_is_next && !an_complete
    && !an_restart |=> bus_rdata == $past(partner_base))
    else $error("base view read wrong");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(rx_page.valid || an_complete
    || (bus_req.wr && bus_req.addr == 5'h1a)))
    else $error("interrupt without cause");
endmodule : lpa_regs_chk

bind lpa_regs lpa_regs_chk chk_u (.clk(clk), .rst_b(rst_b),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .rx_page(rx_page),
  .an_complete(an_complete), .an_restart(an_restart),
  .local_np_able(local_np_able), .partner_base(partner_base),
  .view_is_next(view_is_next), .irq(irq));

`default_nettype wire

// ===== dv/lpa_regs_test.sv
// Purpose: Register level tests of the partner ability block
// Assumes: Reads return data the cycle after the strobe
// Notes: Pages come from the lpa_peer model
`include "lpa_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lpa_regs_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  lpa_pkg::lpa_bus_req_s bus_req = '0;
  logic [15:0] bus_rdata;
  lpa_pkg::lpa_rx_page_s rx_page;
  logic an_complete;
  logic an_restart;
  logic local_np_able;
  lpa_pkg::lpa_base_view_s partner_base;
  logic view_is_next;
  logic irq;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  lpa_peer peer_u (.clk(clk), .rx_page(rx_page), .an_complete(an_complete),
    .an_restart(an_restart), .local_np_able(local_np_able));

  lpa_regs #(.CNT_W(4)) dut_u (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rx_page(rx_page), .an_complete(an_complete),
    .an_restart(an_restart), .local_np_able(local_np_able),
    .partner_base(partner_base), .view_is_next(view_is_next), .irq(irq));

  // ========================================================================
  // Access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(`LPA_ADDR_ABILITY, 16'h0000);
    rd(`LPA_ADDR_STATUS, 16'h0000);
    wr(`LPA_ADDR_IRQ_MASK, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      peer_u.send(1'b0, 16'h0001 << i);
      rd(`LPA_ADDR_ABILITY, (16'h0001 << i) & 16'hefff);
      chk(partner_base, (16'h0001 << i) & 16'hefff);
      chk({15'h0000, irq}, 16'h0001);
      rd(`LPA_ADDR_IRQ_STAT, {11'h000, i > 0, i == 13, 3'h1});
      wr(`LPA_ADDR_IRQ_STAT, 16'h001f);
      rd(`LPA_ADDR_IRQ_STAT, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
    wr(`LPA_ADDR_IRQ_MASK, 16'h0000);
    peer_u.send(1'b0, 16'h1234);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd(`LPA_ADDR_IRQ_STAT, 16'h0011);
    wr(`LPA_ADDR_IRQ_STAT, 16'h0001);
    rd(`LPA_ADDR_IRQ_STAT, 16'h0010);
    wr(`LPA_ADDR_IRQ_MASK, 16'hffff);
    rd(`LPA_ADDR_IRQ_MASK, 16'h001f);
    chk({15'h0000, irq}, 16'h0001);
    wr(`LPA_ADDR_ABILITY, 16'hffff);
    rd(`LPA_ADDR_ABILITY, 16'h0234);
    rd(5'h1f, 16'h0000);
    // Next page exchange, then completion
    peer_u.cfg(1'b0, 1'b1);
    peer_u.send(1'b0, 16'h8001);
    peer_u.send(1'b1, 16'hbda5);
    rd(`LPA_ADDR_ABILITY, 16'h8001);
    peer_u.cfg(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, view_is_next}, 16'h0001);
    rd(`LPA_ADDR_IRQ_STAT, 16'h0017);
    rd(`LPA_ADDR_STATUS, 16'h1f3f);
    rd(`LPA_ADDR_ABILITY, 16'hbda5);
    peer_u.cfg(1'b0, 1'b1);
    rd(`LPA_ADDR_ABILITY, 16'h8001);
    peer_u.cfg(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, view_is_next}, 16'h0000);
    rd(`LPA_ADDR_ABILITY, 16'h8001);
    peer_u.restart();
    rd(`LPA_ADDR_ABILITY, 16'h0000);
    rd(`LPA_ADDR_STATUS, 16'h0000);
    print_verdict();
  end
endmodule : lpa_regs_test

`default_nettype wire
